/* File: hw/lcpr_defs.vh */
// Purpose: Addresses, field positions and reset values of the laser
//          channel protection and regulator configuration bank.
// Assumes: 8-bit register addresses and 8-bit register data.
// Notes:   Definitions only; included by the bank, not by its channel slice.
`ifndef LCPR_DEFS_VH
`define LCPR_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define LCPR_ADDR_STAT0      8'h00
`define LCPR_ADDR_STAT1      8'h01
`define LCPR_ADDR_CH1_CFG    8'h10
`define LCPR_ADDR_CH1_OCTHR  8'h11
`define LCPR_ADDR_CH1_REG    8'h13
`define LCPR_ADDR_CH2_CFG    8'h15
`define LCPR_ADDR_CH2_OCTHR  8'h16
`define LCPR_ADDR_CH2_REG    8'h18
`define LCPR_ADDR_MASK       8'h1D

// ****************************************************************
// Field positions
// ****************************************************************
// Channel configuration register
`define LCPR_CFG_CCM_BIT     0
`define LCPR_CFG_ECAP_BIT    1
`define LCPR_CFG_OCOMP_BIT   4
// Channel regulator register
`define LCPR_REG_SATTHR_LSB  2
`define LCPR_REG_SATTHR_MSB  3
`define LCPR_REG_COMP_LSB    4
`define LCPR_REG_COMP_MSB    6
// Shared mask register
`define LCPR_MSK_OSC_BIT     0
`define LCPR_MSK_SAT1_BIT    2
`define LCPR_MSK_SAT2_BIT    3
`define LCPR_MSK_FOC1_BIT    5
`define LCPR_MSK_FOC2_BIT    6
// First status register
`define LCPR_ST0_OVC2_BIT    4
`define LCPR_ST0_OVC1_BIT    5
`define LCPR_ST0_OSC_BIT     6
// Second status register
`define LCPR_ST1_SAT1_BIT    2
`define LCPR_ST1_SAT2_BIT    6

// ****************************************************************
// Reset values
// ****************************************************************
`define LCPR_RST_OCTHR       8'hFF
`define LCPR_RST_COMP        3'h3
`define LCPR_RST_SATTHR      2'h0
`define LCPR_RST_CCM         1'b0
`define LCPR_RST_ECAP        1'b0
`define LCPR_RST_OCOMP       1'b1
`define LCPR_RST_MSK_OSC     1'b0
`define LCPR_RST_MSK_SAT     1'b1
`define LCPR_RST_FOC         1'b0
`define LCPR_RDATA_IDLE      8'h00
`define LCPR_RST_CHECK_N     1'b1
`define LCPR_RST_DISABLE     2'h0

`endif

/* File: hw/lcpr_sync2.v */
// Purpose: Two-flop synchroniser for asynchronous level inputs.
// Assumes: Inputs are levels that stay stable for several clocks.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns

module lcpr_sync2
#(
  parameter WIDTH = 1
)
(
  input  wire             clock,   // System clock
  input  wire             resetn,  // Asynchronous reset, active low
  input  wire [WIDTH-1:0] async_i, // Level from outside the domain
  output wire [WIDTH-1:0] sync_o   // Level safe to use in the domain
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // ****************************************************************
  // Two stages, cleared by reset
  // ****************************************************************
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

/* File: hw/lcpr_chan_fault.v */
// Purpose: Sticky overcurrent and saturation flags of one laser channel.
// Assumes: Event inputs are already synchronised to clock.
// Notes:   A new event in the clearing cycle keeps the flag set.
`timescale 1ns/1ns

module lcpr_chan_fault
(
  input  wire clock,          // System clock
  input  wire resetn,         // Asynchronous reset, active low
  input  wire ovc_evt,        // Overcurrent seen by the comparator
  input  wire force_ovc,      // Forced overcurrent from software
  input  wire sat_evt,        // Output transistor below threshold
  input  wire clr_ovc,        // First status register was read
  input  wire clr_sat,        // Second status register was read
  output wire overcurrent_flag, // Sticky overcurrent flag
  output wire saturation_flag   // Sticky saturation flag
);

  reg ovc_r;
  reg ovc_nxt;
  reg sat_r;
  reg sat_nxt;

  // ****************************************************************
  // Flag update: set wins over the read clear
  // ****************************************************************
  // Force is reapplied every cycle, so a read cannot drop the flag
  // while forcing stays on.
  always @*
  begin
    ovc_nxt = ovc_evt | force_ovc | (ovc_r & ~clr_ovc);
    sat_nxt = sat_evt | (sat_r & ~clr_sat);
  end

  // Flag registers
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ovc_r <= 1'b0;
      sat_r <= 1'b0;
    end
    else
    begin
      ovc_r <= ovc_nxt;
      sat_r <= sat_nxt;
    end
  end

  assign overcurrent_flag = ovc_r;
  assign saturation_flag  = sat_r;

endmodule

/* File: hw/lcpr_top.v */
// Purpose: Configuration and fault signalling bank for two laser
//          channels: thresholds, regulator settings, masks, status.
// Assumes: The serial front end delivers decoded one-cycle read and
//          write strobes with an 8-bit address on this clock.
// Notes:   Fault and comparator inputs are asynchronous and are
//          synchronised here before use.
`timescale 1ns/1ns
`include "lcpr_defs.vh"

// Summary of operation
// - Channel 1 overcurrent threshold is 8-bit RW, resets 0xFF, 0x0A minimum; lower codes are stored as written, not clamped.
// - Channel 2 overcurrent threshold is separate 8-bit RW, resets 0xFF.
// - Force bit set makes overcurrent flag, low check output, channel off.
// - Forced overcurrent persists until the force bit is cleared.
// - Force bits are RW, reset 0, at mask register bits 5 and 6.
// - External loop capacitor connected only while its enable bit is 1.
// - Three-bit compensation at bits 6:4, resets 011, 111 fastest.
// - Offset compensation enable at bit 4, resets 1, 0 disables.
// - Oscillator fault disables both channels, sets flag, drives check low.
// - Oscillator mask at bit 0, reset 0, hides it from check output.
// - Saturation threshold at bits 3:2, reset 00, selects four voltages.
// - Transistor below threshold sets saturation flag and signals check output.
// - Channel 1 saturation mask at bit 2, resets 1, hides signalling.
// - Current-control mode routes monitor pin to the converter.
// - Channel 2 saturation mask at bit 3, resets 1, hides signalling.
// - Any unmasked status flag drives check output low.
// - Reading status acknowledges errors; required before channels re-enable.
// - Oscillator flag at status 0 bit 6, saturation 1 at status 1 bit 2.
module lcpr_top
(
  input  wire       clock,         // System clock, 100 MHz
  input  wire       resetn,        // Asynchronous reset, active low
  input  wire       reg_wr,        // Register write strobe, one cycle
  input  wire       reg_rd,        // Register read strobe, one cycle
  input  wire [7:0] reg_addr,      // Register address
  input  wire [7:0] reg_wdata,     // Write data
  output wire [7:0] reg_rdata,     // Read data, valid after read
  input  wire [1:0] ovc_detect,    // Overcurrent comparators, async
  input  wire [1:0] sat_detect,    // Saturation comparators, async
  input  wire       osc_watchdog,  // Oscillator watchdog fault, async
  input  wire [1:0] internal_resistor_disable, // External resistor used
  input  wire [1:0] converter_sense_select,    // 1: internal sense node
  output wire       check_output_n,        // Fault signal, active low
  output wire [1:0] chan_disable,          // Laser channel shut off
  output wire [7:0] ch1_ovc_thr_code,      // Channel 1 threshold code
  output wire [7:0] ch2_ovc_thr_code,      // Channel 2 threshold code
  output wire [2:0] ch1_comp_code,         // Channel 1 compensation
  output wire [2:0] ch2_comp_code,         // Channel 2 compensation
  output wire [1:0] ch1_sat_thr_code,      // Channel 1 sat. threshold
  output wire [1:0] ch2_sat_thr_code,      // Channel 2 sat. threshold
  output wire [1:0] loop_cap_node_connect, // External capacitor switch
  output wire [1:0] offset_comp_enable,    // Offset compensation on
  output wire [1:0] current_control_mode,  // Current-control mode
  output wire [1:0] adc_monitor_pin_sel,   // Converter sees monitor pin
  output wire [1:0] adc_sense_node_sel     // Converter sees sense node
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg [7:0] ch1_ovc_thr_r;
  reg [7:0] ch2_ovc_thr_r;
  reg [2:0] ch1_comp_r;
  reg [2:0] ch2_comp_r;
  reg [1:0] ch1_sat_thr_r;
  reg [1:0] ch2_sat_thr_r;
  reg [1:0] ccm_r;
  reg [1:0] ecap_r;
  reg [1:0] ocomp_r;
  reg       msk_osc_r;
  reg [1:0] msk_sat_r;
  reg [1:0] force_ovc_r;
  reg       osc_flag_r;
  reg       osc_flag_nxt;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg       check_n_r;
  reg       check_n_nxt;
  reg [1:0] disable_r;
  reg [1:0] disable_nxt;

  wire [1:0] ovc_sync;
  wire [1:0] sat_sync;
  wire       osc_sync;
  wire [1:0] ovc_flag;
  wire [1:0] sat_flag;
  wire       rd_stat0;
  wire       rd_stat1;
  wire [7:0] stat0_word;
  wire [7:0] stat1_word;
  wire [7:0] cfg1_word;
  wire [7:0] cfg2_word;
  wire [7:0] reg1_word;
  wire [7:0] reg2_word;
  wire [7:0] mask_word;

  // Write decode used by every register group
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = wr & (addr == target);
    end
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  lcpr_sync2 #(.WIDTH(5)) u_sync
  (
    .clock   (clock),
    .resetn  (resetn),
    .async_i ({osc_watchdog, sat_detect, ovc_detect}),
    .sync_o  ({osc_sync, sat_sync, ovc_sync})
  );

  // ****************************************************************
  // Overcurrent threshold registers
  // ****************************************************************
  // Full 8-bit code is stored; codes below the minimum are left for
  // the analogue side to clamp.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ch1_ovc_thr_r <= `LCPR_RST_OCTHR;
      ch2_ovc_thr_r <= `LCPR_RST_OCTHR;
    end
    else
    begin
      if (wr_hit(reg_wr, reg_addr, `LCPR_ADDR_CH1_OCTHR))
        ch1_ovc_thr_r <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, `LCPR_ADDR_CH2_OCTHR))
        ch2_ovc_thr_r <= reg_wdata;
    end
  end

  // ****************************************************************
  // Channel configuration registers
  // ****************************************************************
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ccm_r   <= {2{`LCPR_RST_CCM}};
      ecap_r  <= {2{`LCPR_RST_ECAP}};
      ocomp_r <= {2{`LCPR_RST_OCOMP}};
    end
    else
    begin
      if (wr_hit(reg_wr, reg_addr, `LCPR_ADDR_CH1_CFG))
      begin
        ccm_r[0]   <= reg_wdata[`LCPR_CFG_CCM_BIT];
        ecap_r[0]  <= reg_wdata[`LCPR_CFG_ECAP_BIT];
        ocomp_r[0] <= reg_wdata[`LCPR_CFG_OCOMP_BIT];
      end
      if (wr_hit(reg_wr, reg_addr, `LCPR_ADDR_CH2_CFG))
      begin
        ccm_r[1]   <= reg_wdata[`LCPR_CFG_CCM_BIT];
        ecap_r[1]  <= reg_wdata[`LCPR_CFG_ECAP_BIT];
        ocomp_r[1] <= reg_wdata[`LCPR_CFG_OCOMP_BIT];
      end
    end
  end

  // ****************************************************************
  // Regulator registers: compensation and saturation threshold
  // ****************************************************************
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ch1_comp_r    <= `LCPR_RST_COMP;
      ch2_comp_r    <= `LCPR_RST_COMP;
      ch1_sat_thr_r <= `LCPR_RST_SATTHR;
      ch2_sat_thr_r <= `LCPR_RST_SATTHR;
    end
    else
    begin
      if (wr_hit(reg_wr, reg_addr, `LCPR_ADDR_CH1_REG))
      begin
        ch1_comp_r    <= reg_wdata[`LCPR_REG_COMP_MSB:`LCPR_REG_COMP_LSB];
        ch1_sat_thr_r <=
          reg_wdata[`LCPR_REG_SATTHR_MSB:`LCPR_REG_SATTHR_LSB];
      end
      if (wr_hit(reg_wr, reg_addr, `LCPR_ADDR_CH2_REG))
      begin
        ch2_comp_r    <= reg_wdata[`LCPR_REG_COMP_MSB:`LCPR_REG_COMP_LSB];
        ch2_sat_thr_r <=
          reg_wdata[`LCPR_REG_SATTHR_MSB:`LCPR_REG_SATTHR_LSB];
      end
    end
  end

  // ****************************************************************
  // Shared mask and force register
  // ****************************************************************
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      msk_osc_r   <= `LCPR_RST_MSK_OSC;
      msk_sat_r   <= {2{`LCPR_RST_MSK_SAT}};
      force_ovc_r <= {2{`LCPR_RST_FOC}};
    end
    else if (wr_hit(reg_wr, reg_addr, `LCPR_ADDR_MASK))
    begin
      msk_osc_r      <= reg_wdata[`LCPR_MSK_OSC_BIT];
      msk_sat_r[0]   <= reg_wdata[`LCPR_MSK_SAT1_BIT];
      msk_sat_r[1]   <= reg_wdata[`LCPR_MSK_SAT2_BIT];
      force_ovc_r[0] <= reg_wdata[`LCPR_MSK_FOC1_BIT];
      force_ovc_r[1] <= reg_wdata[`LCPR_MSK_FOC2_BIT];
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // A status read acknowledges that register's flags; an event in the
  // same cycle keeps its flag.
  assign rd_stat0 = reg_rd & (reg_addr == `LCPR_ADDR_STAT0);
  assign rd_stat1 = reg_rd & (reg_addr == `LCPR_ADDR_STAT1);

  lcpr_chan_fault u_ch1
  (
    .clock            (clock),
    .resetn           (resetn),
    .ovc_evt          (ovc_sync[0]),
    .force_ovc        (force_ovc_r[0]),
    .sat_evt          (sat_sync[0]),
    .clr_ovc          (rd_stat0),
    .clr_sat          (rd_stat1),
    .overcurrent_flag (ovc_flag[0]),
    .saturation_flag  (sat_flag[0])
  );

  lcpr_chan_fault u_ch2
  (
    .clock            (clock),
    .resetn           (resetn),
    .ovc_evt          (ovc_sync[1]),
    .force_ovc        (force_ovc_r[1]),
    .sat_evt          (sat_sync[1]),
    .clr_ovc          (rd_stat0),
    .clr_sat          (rd_stat1),
    .overcurrent_flag (ovc_flag[1]),
    .saturation_flag  (sat_flag[1])
  );

  // Oscillator flag, set wins over the acknowledge
  always @*
  begin
    osc_flag_nxt = osc_sync | (osc_flag_r & ~rd_stat0);
  end

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      osc_flag_r <= 1'b0;
    else
      osc_flag_r <= osc_flag_nxt;
  end

  // ****************************************************************
  // Channel disable and check output
  // ****************************************************************
  // Disables follow the flags, not the masks, so a masked fault still
  // shuts the laser off. Saturation is a warning and does not disable.
  always @*
  begin
    disable_nxt = ovc_flag | ovc_sync | force_ovc_r
                | {2{osc_flag_r | osc_sync}};
    check_n_nxt = ~(|ovc_flag
                  | (osc_flag_r & ~msk_osc_r)
                  | (sat_flag[0] & ~msk_sat_r[0])
                  | (sat_flag[1] & ~msk_sat_r[1]));
  end

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      disable_r <= `LCPR_RST_DISABLE;
      check_n_r <= `LCPR_RST_CHECK_N;
    end
    else
    begin
      disable_r <= disable_nxt;
      check_n_r <= check_n_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Fields not held by this bank read as zero.
  assign stat0_word = {1'b0, osc_flag_r, ovc_flag[0], ovc_flag[1],
                       4'h0};
  assign stat1_word = {1'b0, sat_flag[1], 3'h0, sat_flag[0], 2'h0};
  assign cfg1_word  = {3'h0, ocomp_r[0], 2'h0, ecap_r[0], ccm_r[0]};
  assign cfg2_word  = {3'h0, ocomp_r[1], 2'h0, ecap_r[1], ccm_r[1]};
  assign reg1_word  = {1'b0, ch1_comp_r, ch1_sat_thr_r, 2'h0};
  assign reg2_word  = {1'b0, ch2_comp_r, ch2_sat_thr_r, 2'h0};
  assign mask_word  = {1'b0, force_ovc_r[1], force_ovc_r[0], 1'b0,
                       msk_sat_r[1], msk_sat_r[0], 1'b0, msk_osc_r};

  always @*
  begin
    case (reg_addr)
      `LCPR_ADDR_STAT0:     rdata_nxt = stat0_word;
      `LCPR_ADDR_STAT1:     rdata_nxt = stat1_word;
      `LCPR_ADDR_CH1_CFG:   rdata_nxt = cfg1_word;
      `LCPR_ADDR_CH1_OCTHR: rdata_nxt = ch1_ovc_thr_r;
      `LCPR_ADDR_CH1_REG:   rdata_nxt = reg1_word;
      `LCPR_ADDR_CH2_CFG:   rdata_nxt = cfg2_word;
      `LCPR_ADDR_CH2_OCTHR: rdata_nxt = ch2_ovc_thr_r;
      `LCPR_ADDR_CH2_REG:   rdata_nxt = reg2_word;
      `LCPR_ADDR_MASK:      rdata_nxt = mask_word;
      default:              rdata_nxt = `LCPR_RDATA_IDLE;
    endcase
  end

  // Read data is captured on the strobe and held until the next read
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= `LCPR_RDATA_IDLE;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
  end

  // ****************************************************************
  // Analogue control outputs
  // ****************************************************************
  // In current-control mode the internal resistor is unused, so the
  // converter is pointed at the monitor pin.
  assign adc_monitor_pin_sel = current_control_mode
                             | ~converter_sense_select;
  assign adc_sense_node_sel  = ~current_control_mode
                             & converter_sense_select;

  assign reg_rdata             = rdata_r;
  assign check_output_n        = check_n_r;
  assign chan_disable          = disable_r;
  assign ch1_ovc_thr_code      = ch1_ovc_thr_r;
  assign ch2_ovc_thr_code      = ch2_ovc_thr_r;
  assign ch1_comp_code         = ch1_comp_r;
  assign ch2_comp_code         = ch2_comp_r;
  assign ch1_sat_thr_code      = ch1_sat_thr_r;
  assign ch2_sat_thr_code      = ch2_sat_thr_r;
  assign loop_cap_node_connect = ecap_r;
  assign offset_comp_enable    = ocomp_r;
  assign current_control_mode  = ccm_r;

endmodule

/* File: test/lcpr_chk_props.sv */
// Purpose: Port-level temporal checks of the configuration bank.
// Assumes: Strobes never overlap; fault inputs are long levels.
// Notes:   Attached by the bind below the module.
`timescale 1ns/1ns

module lcpr_chk
(
  input wire       clock,                 // System clock
  input wire       resetn,                // Reset, active low
  input wire       reg_wr,                // Write strobe
  input wire       reg_rd,                // Read strobe
  input wire [7:0] reg_addr,              // Address
  input wire [7:0] reg_wdata,             // Write data
  input wire [7:0] reg_rdata,             // Read data
  input wire       osc_watchdog,          // Oscillator fault
  input wire       check_output_n,        // Fault out, low
  input wire [1:0] chan_disable,          // Channel off
  input wire [7:0] ch1_ovc_thr_code,      // Threshold 1
  input wire [7:0] ch2_ovc_thr_code,      // Threshold 2
  input wire [2:0] ch1_comp_code,         // Compensation 1
  input wire [1:0] ch2_sat_thr_code,      // Sat. threshold 2
  input wire [1:0] loop_cap_node_connect, // Capacitor switch
  input wire [1:0] offset_comp_enable     // Offset comp.
);
  reg force1_r; // Mirror of the channel 1 force bit

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // Force bit mirror
  // ****************************************************************
  // Tracks writes, so persistence is checked without internals
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      force1_r <= 1'b0;
    else if (reg_wr && reg_addr == 8'h1D)
      force1_r <= reg_wdata[5];
  end

  a_thr1_write: assert property (reg_wr && reg_addr == 8'h11 |=>
    ch1_ovc_thr_code == $past(reg_wdata)) else $error("thr1 not written");
  a_thr2_write: assert property (reg_wr && reg_addr == 8'h16 |=>
    ch2_ovc_thr_code == $past(reg_wdata)) else $error("thr2 not written");
  a_thr1_readback: assert property (reg_rd && reg_addr == 8'h11 |=>
    reg_rdata == ch1_ovc_thr_code) else $error("thr1 readback wrong");
  a_force_reaction: assert property (reg_wr && reg_addr == 8'h1D &&
    reg_wdata[5] |=> ##1 chan_disable[0] ##1 !check_output_n)
    else $error("forced fault not signalled");
  a_force_holds: assert property (force1_r && $past(force1_r) |->
    chan_disable[0])
    else $error("forced fault released early");
  a_comp_write: assert property (reg_wr && reg_addr == 8'h13 |=>
    ch1_comp_code == $past(reg_wdata[6:4])) else $error("comp wrong");
  a_cfg_write: assert property (reg_wr && reg_addr == 8'h10 |=>
    loop_cap_node_connect[0] == $past(reg_wdata[1]) &&
    offset_comp_enable[0] == $past(reg_wdata[4])) else $error("cfg wrong");
  a_sat_thr_write: assert property (reg_wr && reg_addr == 8'h18 |=>
    ch2_sat_thr_code == $past(reg_wdata[3:2])) else $error("sat thr wrong");
  a_osc_shutdown: assert property ($rose(osc_watchdog) |->
    ##[1:5] chan_disable == 2'b11) else $error("osc fault not shut");
endmodule

bind lcpr_top lcpr_chk i_lcpr_chk (.*);

/* File: test/lcpr_mcu_model.sv */
// Purpose: Controller side choice of the converter sense point.
// Assumes: The controller follows the resistor selection at once.
// Notes:   Behavioural; no register traffic of its own.
`timescale 1ns/1ns

module lcpr_mcu_model
(
  input  wire [1:0] internal_resistor_disable, // External resistor
  output wire [1:0] converter_sense_select     // 1: sense node
);
  // ****************************************************************
  // Sense point
  // ****************************************************************
  // Internal resistor needs the sense node, external the monitor pin
  assign converter_sense_select = ~internal_resistor_disable;
endmodule

/* File: test/lcpr_top_bench.sv */
// Purpose: Self-checking bench of the configuration and fault bank.
// Assumes: Strobe port stands for the serial front end.
// Notes:   Reads are noted in a queue and compared by a monitor.
`timescale 1ns/1ns

module lcpr_top_bench;
  reg        clock = 1'b0;
  reg        resetn = 1'b0;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg  [7:0] reg_addr = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg  [1:0] ovc_detect = 2'b00;
  reg  [1:0] sat_detect = 2'b00;
  reg        osc_watchdog = 1'b0;
  reg  [1:0] internal_resistor_disable = 2'b00;
  wire [7:0] reg_rdata;
  wire       check_output_n;
  wire [1:0] chan_disable, converter_sense_select, cap, ocomp, ccm;
  wire [1:0] mon_sel, sense_sel, sat1, sat2;
  wire [7:0] thr1, thr2;
  wire [2:0] ch1_regulator_compensation, ch2_regulator_compensation;
  integer    seed = 4;
  integer    err_total = 0;
  integer    comparisons = 0;
  integer    i, ch;
  reg  [7:0] d, e;
  reg  [7:0] exq [$];
  reg        rd_seen = 1'b0;
  reg [79:0] rst_a = 80'h1011_1315_1618_1D00_0102;
  reg [79:0] rst_v = 80'h10FF_3010_FF30_0C00_0000;
  reg [47:0] ads = 48'h1011_1315_1618;
  reg [47:0] mks = 48'h13FF_7C13_FF7C;

  // ****************************************************************
  // Clock, design and controller
  // ****************************************************************
  always #5 clock = ~clock;

  lcpr_top i_lcpr_top (.clock(clock), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ovc_detect(ovc_detect),
    .sat_detect(sat_detect), .osc_watchdog(osc_watchdog),
    .internal_resistor_disable(internal_resistor_disable),
    .converter_sense_select(converter_sense_select),
    .check_output_n(check_output_n), .chan_disable(chan_disable),
    .ch1_ovc_thr_code(thr1), .ch2_ovc_thr_code(thr2),
    .ch1_comp_code(ch1_regulator_compensation), .ch2_comp_code(ch2_regulator_compensation),
    .ch1_sat_thr_code(sat1), .ch2_sat_thr_code(sat2),
    .loop_cap_node_connect(cap), .offset_comp_enable(ocomp),
    .current_control_mode(ccm), .adc_monitor_pin_sel(mon_sel),
    .adc_sense_node_sel(sense_sel));

  lcpr_mcu_model i_lcpr_mcu_model (
    .internal_resistor_disable(internal_resistor_disable),
    .converter_sense_select(converter_sense_select));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %0s exp %h seen %h", name, exp, seen);
    end
  end
  endtask

  task wr(input [7:0] a, input [7:0] v);
  begin
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  end
  endtask

  // Expected byte is queued before the strobe goes out
  task rd(input [7:0] a, input [7:0] v);
  begin
    @(posedge clock);
    exq.push_back(v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
  end
  endtask

  // Fault levels {osc, sat, ovc}, then check level and disables
  task ev(input [4:0] f, input [2:0] x);
  begin
    @(posedge clock);
    {osc_watchdog, sat_detect, ovc_detect} <= f;
    repeat (7) @(posedge clock);
    #1;
    chk("check_output_n", {7'h00, check_output_n}, {7'h00, x[2]});
    chk("disable", {6'h00, chan_disable}, {6'h00, x[1:0]});
    @(posedge clock);
    {osc_watchdog, sat_detect, ovc_detect} <= 5'h00;
    repeat (5) @(posedge clock);
  end
  endtask

  task summarize;
  begin
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // ****************************************************************
  // Read monitor and watchdog
  // ****************************************************************
  // Data is registered, so compare one edge after the strobe edge
  always @(posedge clock)
  begin
    if (rd_seen)
    begin
      e = exq.pop_front();
      chk("rdata", reg_rdata, e);
    end
    rd_seen <= reg_rd;
  end

  // Run needs about 420 cycles; cut a hang well after that
  initial
  begin
    #60000;
    err_total = err_total + 1;
    summarize;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    for (i = 9; i >= 0; i = i - 1)
      rd(rst_a[8*i+:8], rst_v[8*i+:8]);
    chk("check_output_n", {7'h00, check_output_n}, 8'h01);
    for (i = 0; i < 48; i = i + 1)
    begin
      d = $random(seed);
      wr(ads[8*(i%6)+:8], d);
      rd(ads[8*(i%6)+:8], d & mks[8*(i%6)+:8]);
    end
    wr(8'h11, 8'h0A);
    chk("thr1", thr1, 8'h0A);
    wr(8'h10, 8'h12);
    wr(8'h13, 8'h7C);
    chk("cap", {7'h00, cap[0]}, 8'h01);
    chk("comp", {5'h00, ch1_regulator_compensation}, 8'h07);
    chk("satthr", {6'h00, sat1}, 8'h03);
    wr(8'h18, 8'h5C);
    chk("ch2_regulator_compensation", {5'h00, ch2_regulator_compensation}, 8'h05);
    wr(8'h10, 8'h10);
    chk("sense", {7'h00, sense_sel[0]}, 8'h01);
    internal_resistor_disable <= 2'b01;
    #1;
    chk("monpin", {7'h00, mon_sel[0]}, 8'h01);
    internal_resistor_disable <= 2'b00;
    wr(8'h10, 8'h11);
    chk("monpin", {7'h00, mon_sel[0]}, 8'h01);
    for (ch = 0; ch < 2; ch = ch + 1)
    begin
      wr(8'h1D, 8'h0C | (8'h20 << ch));
      repeat (3) @(posedge clock);
      #1;
      chk("disable", {6'h00, chan_disable}, 8'h01 << ch);
      chk("check_output_n", {7'h00, check_output_n}, 8'h00);
      rd(8'h00, 8'h20 >> ch);
      rd(8'h00, 8'h20 >> ch);
      wr(8'h1D, 8'h0C);
      rd(8'h00, 8'h20 >> ch);
      rd(8'h00, 8'h00);
      repeat (4) @(posedge clock);
      #1;
      chk("disable", {6'h00, chan_disable}, 8'h00);
      chk("check_output_n", {7'h00, check_output_n}, 8'h01);
    end
    wr(8'h1D, 8'h0D);
    ev(5'h10, 3'b111);
    rd(8'h00, 8'h40);
    rd(8'h00, 8'h00);
    wr(8'h1D, 8'h0C);
    ev(5'h10, 3'b011);
    rd(8'h00, 8'h40);
    rd(8'h00, 8'h00);
    ev(5'h01, 3'b001);
    rd(8'h00, 8'h20);
    rd(8'h00, 8'h00);
    for (ch = 0; ch < 2; ch = ch + 1)
    begin
      wr(8'h1D, 8'h0C);
      ev(5'h04 << ch, 3'b100);
      rd(8'h01, 8'h04 << (4*ch));
      rd(8'h01, 8'h00);
      wr(8'h1D, 8'h0C ^ (8'h04 << ch));
      ev(5'h04 << ch, 3'b000);
      rd(8'h01, 8'h04 << (4*ch));
      rd(8'h01, 8'h00);
    end
    repeat (3) @(posedge clock);
    summarize;
  end
endmodule
